/* File: clh_host_model.sv */
// Purpose: host processor model driving the parallel port pins
// Assumes: pins change at the falling edge of sys_clk
// Notes:   hold_cyc stretches both strobe phases for a slow host
`timescale 1ns/100ps
module clh_host_model
(
  // clock
  input  wire logic       sys_clk,
  // host pins
  output logic            register_choice,
  output logic            rw_sel,
  output logic            strobe,
  output logic [7:0]      bus_in,
  input  wire logic [7:0] bus_out,
  input  wire logic       bus_oe,
  // bus width, high for eight bits
  input  wire logic       wide
);
  int hold_cyc = 4;
  logic oe_seen = 1'b0;  // output enable seen with the read data

  // idle pins from time zero
  initial
  begin
    register_choice = 1'b0;
    rw_sel          = 1'b0;
    strobe          = 1'b0;
    bus_in          = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one strobe cycle, read data taken while strobe is still high
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                      output logic [7:0] q);
    register_choice = rs;
    rw_sel          = rw;
    bus_in          = rw ? ~bus_in : d;  // released lines never hold last value
    strobe          = 1'b1;
    repeat (hold_cyc + 2) @(negedge sys_clk);
    q      = bus_out;
    oe_seen = bus_oe;
    strobe = 1'b0;
    repeat (hold_cyc) @(negedge sys_clk);
  endtask : xfer

  // one byte, split into two nibble transfers on a narrow bus
  task automatic acc(input logic rs, input logic rw, input logic [7:0] d,
                     output logic [7:0] q);
    logic [7:0] hi;
    logic [7:0] lo;
    if (wide)
      xfer(rs, rw, d, q);
    else
    begin
      xfer(rs, rw, {d[7:4], ~d[3:0]}, hi);
      xfer(rs, rw, {d[3:0], ~d[7:4]}, lo);
      q = {hi[7:4], lo[7:4]};
    end
  endtask : acc

  // poll status until the work flag is low, then leave one spare cycle
  task automatic wait_ready(output bit ok);
    logic [7:0] st;
    ok = 1'b0;
    for (int i = 0; i < 200 && !ok; i++)
      begin
        acc(1'b0, 1'b1, 8'h00, st);
        ok = (st[7] === 1'b0);
      end
    @(negedge sys_clk);
  endtask : wait_ready
endmodule : clh_host_model

/* File: clh_host_port.sv */
// Purpose: host side parallel port, command and data registers, memories
// Assumes: host pins are asynchronous to sys_clk and held stable around strobe
// Notes:   width, line count and font come in as plain configuration ports
`timescale 1ns/100ps
module clh_host_port
  import clh_pkg::*;
#(
  parameter int CLEAR_CNT = CLEAR_CYCLES,
  parameter int EXEC_CNT  = EXEC_CYCLES
)
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // host pins
  input  wire logic             register_choice,
  input  wire logic             rw_sel,
  input  wire logic             strobe,
  input  wire logic [7:0]       bus_in,
  output logic      [7:0]       bus_out,
  output logic                  bus_oe,
  // configuration
  input  wire logic             bus_width_select,
  input  wire logic             two_line_mode,
  input  wire logic             tall_font,
  // status
  output logic                  internal_work_flag,
  output logic      [6:0]       ram_pointer,
  // display drive
  output logic      [SEG_W-1:0] seg_out,
  output logic      [ROW_W-1:0] row_drive_line
);

  initial
  begin
    if (CLEAR_CNT < 1 || EXEC_CNT < 1 || CLEAR_CNT >= (1 << BUSY_W) || EXEC_CNT >= (1 << BUSY_W))
      $error("operation counts out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and strobe edge
  logic [10:0] s1_ff;
  logic [10:0] s2_ff;
  logic        stb_d_ff;

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_ff    <= '0;
      s2_ff    <= '0;
      stb_d_ff <= 1'b0;
    end
    else
    begin
      s1_ff    <= {register_choice, rw_sel, strobe, bus_in};
      s2_ff    <= s1_ff;
      stb_d_ff <= s2_ff[8];
    end
  end

  wire       rs_s  = s2_ff[10];
  wire       rw_s  = s2_ff[9];
  wire       stb_s = s2_ff[8];
  wire [7:0] bus_s = s2_ff[7:0];
  wire       fall  = stb_d_ff & ~stb_s;

  ////////////////////////////////////////////////////////////////////////////////
  // state
  logic [7:0]        cmd_ff;       // command holding register
  logic [7:0]        dtr_ff;       // data transfer register
  logic [6:0]        ptr_ff;
  logic              glyph_sel_ff;
  logic              dir_ff;
  logic              scroll_ff;
  logic [6:0]        ofs_ff;
  logic              busy_ff;
  logic [BUSY_W-1:0] busy_cnt_ff;
  logic              nib_ff;
  logic [3:0]        hi_ff;
  logic              reload_ff;
  logic [7:0]        bus_out_ff;
  logic [7:0]        text_mem  [TEXT_DEPTH];
  logic [4:0]        glyph_mem [GLYPH_DEPTH];

  ////////////////////////////////////////////////////////////////////////////////
  // access decode and nibble pairing
  wire       wide   = bus_width_select;
  wire       xfer   = fall & (wide | nib_ff);
  wire [7:0] byte_i = wide ? bus_s : {hi_ff, bus_s[7:4]};
  clh_acc_t  acc;
  assign acc = clh_acc_t'({rs_s, rw_s});
  wire cmd_wr = xfer & (acc == CLH_CMD_WR) & ~busy_ff;
  wire dat_wr = xfer & (acc == CLH_DAT_WR) & ~busy_ff;
  wire dat_rd = xfer & (acc == CLH_DAT_RD);
  wire do_clr = cmd_wr & (byte_i == CMD_CLEAR);
  wire do_hom = cmd_wr & (byte_i[7:2] == 6'h00) & byte_i[BIT_HOME];
  wire do_ent = cmd_wr & (byte_i[7:3] == 5'h00) & byte_i[BIT_ENTRY];
  wire do_gst = cmd_wr & (byte_i[7:6] == 2'b01);
  wire do_tst = cmd_wr & byte_i[BIT_TSET];

  ////////////////////////////////////////////////////////////////////////////////
  // pointer stepping and text index mapping
  wire [6:0] p_inc = ptr_ff + 7'h01;
  wire [6:0] p_dec = ptr_ff - 7'h01;
  wire [6:0] t_inc = two_line_mode ? ((ptr_ff == L1_LAST) ? L2_FIRST :
                     (ptr_ff == L2_LAST) ? 7'h00 : p_inc) :
                     ((ptr_ff == ONE_LAST) ? 7'h00 : p_inc);
  wire [6:0] t_dec = two_line_mode ? ((ptr_ff == 7'h00) ? L2_LAST :
                     (ptr_ff == L2_FIRST) ? L1_LAST : p_dec) :
                     ((ptr_ff == 7'h00) ? ONE_LAST : p_dec);
  wire [6:0] g_nxt = {1'b0, dir_ff ? p_inc[5:0] : p_dec[5:0]};
  wire [6:0] stepped = glyph_sel_ff ? g_nxt : (dir_ff ? t_inc : t_dec);
  wire [6:0] t_idx = (two_line_mode & ptr_ff[6]) ?
                     ptr_ff - L2_FIRST + 7'(LINE_LEN) : ptr_ff;
  wire       t_ok  = t_idx < 7'(TEXT_DEPTH);
  wire [7:0] mem_rd = glyph_sel_ff ? {3'h0, glyph_mem[ptr_ff[5:0]]} :
                      (t_ok ? text_mem[t_idx] : 8'h00);
  wire [6:0] span  = two_line_mode ? 7'(LINE_LEN) : 7'(TEXT_DEPTH);
  wire [6:0] o_inc = (ofs_ff == span - 7'h01) ? 7'h00 : ofs_ff + 7'h01;
  wire [6:0] o_dec = (ofs_ff == 7'h00) ? span - 7'h01 : ofs_ff - 7'h01;

  ////////////////////////////////////////////////////////////////////////////////
  // command, pointer, mode and busy registers
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmd_ff       <= 8'h00;
      ptr_ff       <= 7'h00;
      glyph_sel_ff <= 1'b0;
      dir_ff       <= 1'b1;
      scroll_ff    <= 1'b0;
      ofs_ff       <= 7'h00;
      busy_ff      <= 1'b0;
      busy_cnt_ff  <= '0;
      nib_ff       <= 1'b0;
      hi_ff        <= 4'h0;
    end
    else
    begin
      if (fall & ~wide)
        nib_ff <= ~nib_ff;
      if (fall & ~wide & ~nib_ff)
        hi_ff <= bus_s[7:4];
      if (cmd_wr)
        cmd_ff <= byte_i;
      if (busy_ff)
      begin
        busy_cnt_ff <= busy_cnt_ff - BUSY_W'(1);
        busy_ff     <= (busy_cnt_ff != BUSY_W'(1));
      end
      if (cmd_wr | dat_wr)
      begin
        busy_ff     <= 1'b1;
        busy_cnt_ff <= (do_clr | do_hom) ? BUSY_W'(CLEAR_CNT) : BUSY_W'(EXEC_CNT);
      end
      if (do_clr)
      begin
        ptr_ff       <= 7'h00;
        glyph_sel_ff <= 1'b0;
        dir_ff       <= 1'b1;
        ofs_ff       <= 7'h00;
      end
      else if (do_hom)
      begin
        ptr_ff       <= 7'h00;
        glyph_sel_ff <= 1'b0;
        ofs_ff       <= 7'h00;
      end
      else if (do_ent)
      begin
        dir_ff    <= byte_i[1];
        scroll_ff <= byte_i[0];
      end
      else if (do_tst)
      begin
        ptr_ff       <= byte_i[6:0];
        glyph_sel_ff <= 1'b0;
      end
      else if (do_gst)
      begin
        ptr_ff       <= {1'b0, byte_i[5:0]};
        glyph_sel_ff <= 1'b1;
      end
      if (dat_wr | dat_rd)
        ptr_ff <= stepped;
      if (dat_wr & scroll_ff & ~glyph_sel_ff)
        ofs_ff <= dir_ff ? o_inc : o_dec;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // data transfer register and its automatic reload
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dtr_ff    <= 8'h00;
      reload_ff <= 1'b0;
    end
    else
    begin
      reload_ff <= dat_rd | do_tst | do_gst | do_clr | do_hom;
      if (dat_wr)
        dtr_ff <= byte_i;
      else if (reload_ff)
        dtr_ff <= mem_rd;
    end
  end

  // memories: no reset, clear fills the text with spaces
  always_ff @(posedge sys_clk)
  begin
    if (do_clr)
    begin
      for (int i = 0; i < TEXT_DEPTH; i++)
        text_mem[i] <= SPACE_CODE;
    end
    else if (dat_wr & ~glyph_sel_ff & t_ok)
      text_mem[t_idx] <= byte_i;
    if (dat_wr & glyph_sel_ff)
      glyph_mem[ptr_ff[5:0]] <= byte_i[4:0];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path: status or data, never the command register
  wire [7:0] rd_byte = rs_s ? dtr_ff : {busy_ff, ptr_ff};
  wire [7:0] rd_lane = wide ? rd_byte :
                       {(nib_ff ? rd_byte[3:0] : rd_byte[7:4]), 4'h0};

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      bus_out_ff <= 8'h00;
    else
      bus_out_ff <= rd_lane;
  end

  assign bus_out            = bus_out_ff;
  assign bus_oe             = rw_s & stb_s;
  assign internal_work_flag = busy_ff;
  assign ram_pointer        = ptr_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // scan feed: text code to glyph row
  logic [2:0] col_idx;
  logic [2:0] dot_idx;
  logic [3:0] row_idx;

  wire [4:0] duty   = two_line_mode ? 5'h10 : (tall_font ? 5'h0b : 5'h08);
  wire       line2  = two_line_mode & row_idx[3];
  wire [3:0] g_row  = two_line_mode ? {1'b0, row_idx[2:0]} : row_idx;
  wire [6:0] pos_r  = ofs_ff + {4'h0, col_idx};
  wire [6:0] pos    = (pos_r >= span) ? pos_r - span : pos_r;
  wire [6:0] s_idx  = line2 ? pos + 7'(LINE_LEN) : pos;
  wire [7:0] code   = text_mem[s_idx];
  wire       user_g = (code[7:4] == 4'h0);
  wire [4:0] u_row  = g_row[3] ? 5'h00 : glyph_mem[{code[2:0], g_row[2:0]}];
  wire       rom8   = (code >= ROM8_FIRST) & (code <= ROM8_LAST) & ~g_row[3];
  wire       rom11  = (code >= ROM11_FIRST) & (g_row < 4'hb);
  wire [4:0] f_row  = (rom8 | rom11) ? (code[4:0] ^ {g_row, 1'b1}) : 5'h00;
  wire [4:0] row_px = user_g ? u_row : f_row;
  wire       pix    = row_px[3'(DOTS - 1) - dot_idx];

  clh_row_scan #(.ROW_CYCLES(ROW_CYC)) u_scan (
    .sys_clk        (sys_clk),
    .rstn           (rstn),
    .duty_rows      (duty),
    .pix            (pix),
    .col_idx        (col_idx),
    .dot_idx        (dot_idx),
    .row_idx        (row_idx),
    .seg_out        (seg_out),
    .row_drive_line (row_drive_line)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  AST_BUSY_SET: assert property (@(posedge sys_clk) disable iff (!rstn)
    cmd_wr |=> busy_ff) else $error("busy not raised by instruction");
  AST_REFUSE: assert property (@(posedge sys_clk) disable iff (!rstn)
    (busy_ff && fall && acc == CLH_CMD_WR) |=> $stable(cmd_ff)) else $error("instruction taken while busy");
  AST_BUSY_END: assert property (@(posedge sys_clk) disable iff (!rstn)
    (busy_ff && busy_cnt_ff == BUSY_W'(1) && !cmd_wr && !dat_wr) |=> !busy_ff)
    else $error("busy did not clear at count end");
  AST_CLEAR: assert property (@(posedge sys_clk) disable iff (!rstn)
    do_clr |=> (ptr_ff == 7'h00 && dir_ff && ofs_ff == 7'h00)) else $error("clear state wrong");
  AST_HOME: assert property (@(posedge sys_clk) disable iff (!rstn)
    do_hom |=> (ptr_ff == 7'h00 && ofs_ff == 7'h00)) else $error("home state wrong");
  AST_WRAP2: assert property (@(posedge sys_clk) disable iff (!rstn)
    (dat_wr && two_line_mode && !glyph_sel_ff && dir_ff && ptr_ff == L1_LAST)
    |=> ptr_ff == L2_FIRST) else $error("line one did not wrap to line two");
  AST_GSTEP: assert property (@(posedge sys_clk) disable iff (!rstn)
    (dat_rd && glyph_sel_ff && !dir_ff) |=> ptr_ff == {1'b0, $past(ptr_ff[5:0]) - 6'h01})
    else $error("glyph pointer did not step down");
  AST_STATUS: assert property (@(posedge sys_clk) disable iff (!rstn)
    (wide && !rs_s && rw_s) |=> bus_out[7:0] == {$past(busy_ff), $past(ptr_ff)})
    else $error("status read wrong");
  AST_NARROW: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(!wide) |-> bus_out[3:0] == 4'h0) else $error("low lines driven in narrow mode");
  AST_OE_LOW: assert property (@(posedge sys_clk) disable iff (!rstn)
    bus_oe |-> ($past(strobe, 2) && $past(rw_sel, 2)))
    else $error("bus driven without a read strobe");
  AST_SCROLL: assert property (@(posedge sys_clk) disable iff (!rstn)
    (dat_wr && !scroll_ff) |=> $stable(ofs_ff)) else $error("shift without auto scroll");
  AST_SHIFT: assert property (@(posedge sys_clk) disable iff (!rstn)
    (dat_wr && scroll_ff && !glyph_sel_ff) |=> !$stable(ofs_ff))
    else $error("auto scroll did not shift");

  COV_CLEAR: cover property (@(posedge sys_clk) disable iff (!rstn) do_clr ##[1:8] busy_ff);
  COV_READ:  cover property (@(posedge sys_clk) disable iff (!rstn) dat_rd ##1 reload_ff);
  COV_NIB:   cover property (@(posedge sys_clk) disable iff (!rstn) dat_wr && !wide);

endmodule : clh_host_port

/* File: clh_host_port_tb_top.sv */
// Purpose: self-checking bench for the host port core
// Assumes: host model moves pins at the falling clock edge
// Notes:   execution counts shrunk so busy periods stay short
`timescale 1ns/100ps
`define CHK(g, e) \
  begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module clh_host_port_tb_top;
  logic        sys_clk;
  logic        rstn;
  logic        register_choice;
  logic        rw_sel;
  logic        strobe;
  logic [7:0]  bus_in;
  logic [7:0]  bus_out;
  logic        bus_oe;
  logic        bus_width_select = 1'b1;
  logic        two_line_mode    = 1'b0;
  logic        tall_font        = 1'b0;
  logic        internal_work_flag;
  logic [6:0]  ram_pointer;
  logic [39:0] seg_out;
  logic [15:0] row_drive_line;
  int          fail_count  = 0;
  int          comparisons = 0;
  logic [7:0]  q;
  bit          ok;

  // design and host model
  clh_host_port #(.CLEAR_CNT(40), .EXEC_CNT(6)) dut_u (.sys_clk(sys_clk), .rstn(rstn),
    .register_choice(register_choice), .rw_sel(rw_sel), .strobe(strobe), .bus_in(bus_in),
    .bus_out(bus_out), .bus_oe(bus_oe), .bus_width_select(bus_width_select),
    .two_line_mode(two_line_mode), .tall_font(tall_font),
    .internal_work_flag(internal_work_flag), .ram_pointer(ram_pointer),
    .seg_out(seg_out), .row_drive_line(row_drive_line));
  clh_host_model host_u (.sys_clk(sys_clk), .register_choice(register_choice),
    .rw_sel(rw_sel), .strobe(strobe), .bus_in(bus_in), .bus_out(bus_out),
    .bus_oe(bus_oe), .wide(bus_width_select));

  // 40 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic tally_and_finish();
    $display("counts: comparisons=%0d mismatches=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // wait for the work flag to drop, give up after a bounded poll
  task automatic ready();
    host_u.wait_ready(ok);
    if (!ok)
    begin
      fail_count++;
      tally_and_finish();
    end
  endtask : ready

  // host accesses after a ready poll
  task automatic acc(input logic rs, input logic rw, input logic [7:0] d);
    ready();
    host_u.acc(rs, rw, d, q);
  endtask : acc

  ////////////////////////////////////////////////////////////////////////////////
  // clear with a refused command while busy
  task automatic t_clear();
    acc(1'b0, 1'b0, 8'h85);
    acc(1'b1, 1'b0, 8'h99);
    acc(1'b0, 1'b0, 8'h01);
    repeat (2) @(negedge sys_clk);
    `CHK(internal_work_flag, 1'b1)
    host_u.acc(1'b0, 1'b0, 8'ha0, q);
    acc(1'b0, 1'b1, 8'h00);
    `CHK(q, 8'h00)
    acc(1'b0, 1'b0, 8'h85);
    acc(1'b1, 1'b1, 8'h00);
    `CHK(q, 8'h20)
    acc(1'b0, 1'b1, 8'h00);
    `CHK(q, 8'h06)
    $display("test clear done");
  endtask : t_clear

  // back to back writes then reads with auto reload
  task automatic t_rw();
    acc(1'b0, 1'b0, 8'h90);
    acc(1'b1, 1'b0, 8'h41);
    acc(1'b1, 1'b0, 8'h42);
    `CHK(host_u.oe_seen, 1'b0)
    acc(1'b0, 1'b1, 8'h00);
    `CHK(q, 8'h12)
    acc(1'b0, 1'b0, 8'h90);
    acc(1'b1, 1'b1, 8'h00);
    `CHK(q, 8'h41)
    `CHK(host_u.oe_seen, 1'b1)
    `CHK(bus_oe, 1'b0)
    acc(1'b1, 1'b1, 8'h00);
    `CHK(q, 8'h42)
    $display("test write read done");
  endtask : t_rw

  // every entry mode, then return home
  task automatic t_entry();
    for (int m = 4; m < 8; m++)
      begin
        acc(1'b0, 1'b0, 8'(m));
        acc(1'b0, 1'b0, 8'h90);
        acc(1'b1, 1'b0, 8'(m));
        acc(1'b0, 1'b1, 8'h00);
        `CHK(q, m[1] ? 8'h11 : 8'h0f)
      end
    acc(1'b0, 1'b0, 8'h03);
    acc(1'b0, 1'b1, 8'h00);
    `CHK(q, 8'h00)
    acc(1'b0, 1'b0, 8'h90);
    acc(1'b1, 1'b1, 8'h00);
    `CHK(q, 8'h07)
    $display("test entry done");
  endtask : t_entry

  // glyph memory write and read back
  task automatic t_glyph();
    acc(1'b0, 1'b0, 8'h48);
    acc(1'b1, 1'b0, 8'hff);
    acc(1'b0, 1'b1, 8'h00);
    `CHK(q, 8'h09)
    acc(1'b0, 1'b0, 8'h04);
    acc(1'b0, 1'b0, 8'h48);
    acc(1'b1, 1'b1, 8'h00);
    `CHK(q[4:0], 5'h1f)
    acc(1'b0, 1'b1, 8'h00);
    `CHK(q, 8'h07)
    acc(1'b0, 1'b0, 8'h06);
    $display("test glyph done");
  endtask : t_glyph

  // line boundary addresses, two lines then one line
  task automatic t_lines();
    logic [6:0] adr [5] = '{7'h00, 7'h27, 7'h40, 7'h67, 7'h4f};
    for (int i = 0; i < 5; i++)
      begin
        two_line_mode = (i < 4);
        acc(1'b0, 1'b0, {1'b1, adr[i]});
        acc(1'b1, 1'b0, {1'b0, adr[i]} ^ 8'h5a);
        acc(1'b0, 1'b0, {1'b1, adr[i]});
        acc(1'b1, 1'b1, 8'h00);
        `CHK(q, {1'b0, adr[i]} ^ 8'h5a)
      end
    $display("test lines done");
  endtask : t_lines

  // slow host on the four bit bus
  task automatic t_nibble();
    bus_width_select = 1'b0;
    host_u.hold_cyc  = 8;
    acc(1'b0, 1'b0, 8'ha0);
    acc(1'b1, 1'b0, 8'ha7);
    acc(1'b0, 1'b0, 8'ha0);
    acc(1'b1, 1'b1, 8'h00);
    `CHK(q, 8'ha7)
    acc(1'b0, 1'b1, 8'h00);
    `CHK(q, 8'h21)
    bus_width_select = 1'b1;
    host_u.hold_cyc  = 4;
    $display("test nibble done");
  endtask : t_nibble

  // rows used for each duty, one row at a time
  task automatic t_scan();
    logic [15:0] seen;
    logic        multi;
    acc(1'b0, 1'b0, 8'h80);
    acc(1'b1, 1'b0, 8'h01);
    for (int k = 0; k < 3; k++)
      begin
        two_line_mode = (k == 2);
        tall_font     = (k == 1);
        repeat (1100) @(negedge sys_clk);
        seen  = 16'h0000;
        multi = 1'b0;
        repeat (1100)
        begin
          @(negedge sys_clk);
          seen  |= row_drive_line;
          multi |= ($countones(row_drive_line) > 1);
          if (k == 0 && row_drive_line[0])
            `CHK(seg_out[39:35], 5'h1f)
        end
        `CHK(seen, k == 0 ? 16'h00ff : (k == 1 ? 16'h07ff : 16'hffff))
        `CHK(multi, 1'b0)
      end
    $display("test scan done");
  endtask : t_scan

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    rstn = 1'b0;
    repeat (10) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK(internal_work_flag, 1'b0)
    `CHK(ram_pointer, 7'h00)
    t_clear();
    t_rw();
    t_entry();
    t_glyph();
    t_lines();
    t_nibble();
    t_scan();
    tally_and_finish();
  end
endmodule : clh_host_port_tb_top

/* File: clh_pkg.sv */
// Purpose: shared constants for the character display host port core
// Assumes: 40 MHz system clock, byte wide command and data codes
// Notes:   times in ns, cycle counts derived from them
package clh_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int CLEAR_TIME_NS = 1530000;  // clear and home execution
  localparam int EXEC_TIME_NS  = 39000;    // other operations
  localparam int CLEAR_CYCLES  = (CLEAR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXEC_CYCLES   = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_W        = 18;

  // memory sizes and address ranges
  localparam int        TEXT_DEPTH  = 80;
  localparam int        GLYPH_DEPTH = 64;
  localparam int        LINE_LEN    = 40;
  localparam logic [6:0] ONE_LAST   = 7'h4f;
  localparam logic [6:0] L1_LAST    = 7'h27;
  localparam logic [6:0] L2_FIRST   = 7'h40;
  localparam logic [6:0] L2_LAST    = 7'h67;
  localparam logic [7:0] SPACE_CODE = 8'h20;

  // fixed glyph table code ranges
  localparam logic [7:0] ROM8_FIRST  = 8'h10;
  localparam logic [7:0] ROM8_LAST   = 8'hdb;  // 204 short patterns
  localparam logic [7:0] ROM11_FIRST = 8'he0;  // 32 tall patterns

  // scan geometry
  localparam int SEG_W   = 40;
  localparam int ROW_W   = 16;
  localparam int DOTS    = 5;
  localparam int ROW_CYC = 64;

  // instruction decode
  localparam logic [7:0] CMD_CLEAR = 8'h01;
  localparam int         BIT_HOME  = 1;
  localparam int         BIT_ENTRY = 2;
  localparam int         BIT_GSET  = 6;
  localparam int         BIT_TSET  = 7;

  // host access kinds from register choice and direction
  typedef enum logic [1:0] {
    CLH_CMD_WR  = 2'b00,
    CLH_STAT_RD = 2'b01,
    CLH_DAT_WR  = 2'b10,
    CLH_DAT_RD  = 2'b11
  } clh_acc_t;

endpackage : clh_pkg

/* File: clh_row_scan.sv */
// Purpose: row scan engine, serial segment shift and latch, one-hot row drive
// Assumes: pixel input is valid for the column and dot shown on col and dot outputs
// Notes:   one row is shifted in per ROW_CYCLES cycles
`timescale 1ns/100ps
module clh_row_scan
  import clh_pkg::*;
#(
  parameter int ROW_CYCLES = ROW_CYC
)
(
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // duty and pixel feed
  input  wire logic [4:0]       duty_rows,
  input  wire logic             pix,
  output logic      [2:0]       col_idx,
  output logic      [2:0]       dot_idx,
  output logic      [3:0]       row_idx,
  // display drive
  output logic      [SEG_W-1:0] seg_out,
  output logic      [ROW_W-1:0] row_drive_line
);

  initial
  begin
    if (ROW_CYCLES <= SEG_W || ROW_CYCLES > 255)
      $error("row period must exceed the shift length");
  end

  logic [7:0]       cnt_ff;
  logic [2:0]       col_ff;
  logic [2:0]       dot_ff;
  logic [3:0]       row_ff;
  logic [SEG_W-1:0] shift_ff;
  logic [SEG_W-1:0] seg_ff;
  logic [ROW_W-1:0] drv_ff;

  wire row_end   = (cnt_ff == 8'(ROW_CYCLES - 1));
  wire shifting  = (cnt_ff < 8'(SEG_W));
  wire latch_now = (cnt_ff == 8'(SEG_W));
  wire last_row  = ({1'b0, row_ff} >= duty_rows - 5'h01);

  // shift serially, then move to the segment latch and select the row
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_ff   <= 8'h00;
      col_ff   <= 3'h0;
      dot_ff   <= 3'h0;
      row_ff   <= 4'h0;
      shift_ff <= '0;
      seg_ff   <= '0;
      drv_ff   <= '0;
    end
    else
    begin
      cnt_ff <= row_end ? 8'h00 : cnt_ff + 8'h01;
      if (shifting)
      begin
        shift_ff <= {shift_ff[SEG_W-2:0], pix};
        dot_ff   <= (dot_ff == 3'(DOTS - 1)) ? 3'h0 : dot_ff + 3'h1;
        col_ff   <= (dot_ff == 3'(DOTS - 1)) ? col_ff + 3'h1 : col_ff;
      end
      if (latch_now)
      begin
        seg_ff <= shift_ff;
        drv_ff <= ROW_W'(1) << row_ff;
      end
      if (row_end)
      begin
        col_ff <= 3'h0;
        dot_ff <= 3'h0;
        row_ff <= last_row ? 4'h0 : row_ff + 4'h1;
      end
    end
  end

  assign col_idx        = col_ff;
  assign dot_idx        = dot_ff;
  assign row_idx        = row_ff;
  assign seg_out        = seg_ff;
  assign row_drive_line = drv_ff;

endmodule : clh_row_scan
